// *** rtl/sisr_defines.vh ***
// Purpose : constants for the socket identification and status registers
// Assumes : byte-wide register port, offsets relative to the socket base
// Notes   : included by every design file of the block
`ifndef SISR_DEFINES_VH
`define SISR_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SISR_ADDR_W          12
`define SISR_IDENT_OFS       12'h800
`define SISR_STATUS_OFS      12'h801

// ----------------------------------------------------------------------
// identification register fields
// ----------------------------------------------------------------------
`define SISR_KIND_HI         7
`define SISR_KIND_LO         6
`define SISR_SPARE_HI        5
`define SISR_SPARE_LO        4
`define SISR_REV_HI          3
`define SISR_REV_LO          0
`define SISR_INTERFACE_KIND  2'h2
`define SISR_SPARE_RST       2'h0
`define SISR_LEGACY_REV      4'h2

// ----------------------------------------------------------------------
// interface status register fields
// ----------------------------------------------------------------------
`define SISR_ST_RSVD         7
`define SISR_ST_POWER        6
`define SISR_ST_READY        5
`define SISR_ST_WP           4
`define SISR_ST_CD_B         3
`define SISR_ST_CD_A         2
`define SISR_ST_LOW_HI       1
`define SISR_ST_LOW_LO       0

// ----------------------------------------------------------------------
// power control mirror fields
// ----------------------------------------------------------------------
`define SISR_PWR_LEG_EN      4
`define SISR_PWR_VCC_HI      4
`define SISR_PWR_VCC_LO      3
`define SISR_PWR_VCC_OFF     2'h0

`endif

// *** rtl/sisr_status_capture.v ***
// Purpose : samples the card pins and forms the live status bits
// Assumes : card pins are synchronous to i_core_clk
// Notes   : low two bits are chosen by the card type input
`timescale 1ns/100ps
`include "sisr_defines.vh"

module sisr_status_capture (
   input  wire       i_core_clk,
   input  wire       i_rst_n,
   input  wire       i_card_is_io,
   input  wire       i_card_ready_pin,
   input  wire       i_card_write_protect_pin,
   input  wire       i_card_detect_a_pin_n,
   input  wire       i_card_detect_b_pin_n,
   input  wire       i_battery_detect_a_pin,
   input  wire       i_battery_detect_b_pin,
   input  wire       i_card_speaker_pin,
   input  wire       i_card_status_change_pin,
   output reg  [5:0] o_live_status,
   output reg        o_live_changed
);

   reg  [5:0] live_d;
   reg  [1:0] low_d;

   // -------------------------------------------------------------------
   // pin mapping
   // -------------------------------------------------------------------
   always @* begin
      if (i_card_is_io) begin
         low_d = {i_card_speaker_pin, i_card_status_change_pin};
      end else begin
         low_d = {i_battery_detect_b_pin, i_battery_detect_a_pin};
      end
      live_d = {i_card_ready_pin,
                i_card_write_protect_pin,
                ~i_card_detect_b_pin_n,
                ~i_card_detect_a_pin_n,
                low_d};
   end

   // -------------------------------------------------------------------
   // sample register
   // -------------------------------------------------------------------
   // pins keep being sampled during reset: these bits have no fixed
   // reset value, only the change pulse is held quiet
   always @(posedge i_core_clk) begin
      o_live_status <= live_d;
      if (!i_rst_n) begin
         o_live_changed <= 1'b0;
      end else begin
         o_live_changed <= (live_d != o_live_status);
      end
   end

endmodule

// *** rtl/sisr_regs.v ***
// Purpose : socket identification/revision and interface status registers
// Assumes : i_rst_n is the global reset; byte port at the printed offsets
// Notes   : read data is returned one cycle after the read strobe
// Contract
// - identification bits 7:6 are read-only and always read binary 10.
// - identification bits 5:4 are plain read/write spare storage.
// - identification bits 3:0 hold a writable revision, loaded on reset.
// - writing 0010 to the revision field selects the legacy register mode.
// - while the write lock is set the identification register ignores writes.
// - identification fields return to reset values only by the global reset.
// - status register is read-only; bit 7 reads zero, writes do nothing.
// - status bit 6 shows socket power on, derived from power programming.
// - status bit 5 follows the card ready pin.
// - status bit 4 follows the card write-protect pin.
// - status bit 3 is the inverted second card-detect pin.
// - status bit 2 is the inverted first card-detect pin.
// - memory card: bit 0 mirrors battery line 1, bit 1 battery line 2.
// - I/O card: bit 1 mirrors speaker, bit 0 mirrors status change.
// - after reset the top two status bits read zero, others live.
`timescale 1ns/100ps
`include "sisr_defines.vh"

module sisr_regs #(
   parameter [3:0] REV_RESET = 4'h1  // arbitrary neutral revision value
) (
   input  wire                    i_core_clk,
   input  wire                    i_rst_n,
   input  wire [`SISR_ADDR_W-1:0] i_reg_addr,
   input  wire                    i_reg_wr,
   input  wire                    i_reg_rd,
   input  wire [7:0]              i_reg_wdata,
   output reg  [7:0]              o_reg_rdata,
   output reg                     o_reg_rvalid,
   input  wire                    i_subsystem_write_lock,
   input  wire [7:0]              i_power_ctrl,
   input  wire                    i_card_is_io,
   input  wire                    i_card_ready_pin,
   input  wire                    i_card_write_protect_pin,
   input  wire                    i_card_detect_a_pin_n,
   input  wire                    i_card_detect_b_pin_n,
   input  wire                    i_battery_detect_a_pin,
   input  wire                    i_battery_detect_b_pin,
   input  wire                    i_card_speaker_pin,
   input  wire                    i_card_status_change_pin,
   output wire                    o_legacy_mode,
   output reg                     o_socket_power_on,
   output wire                    o_card_fully_seated,
   output wire                    o_status_changed
);

   // -------------------------------------------------------------------
   // decode helpers
   // -------------------------------------------------------------------
   function hit;
      input [`SISR_ADDR_W-1:0] addr;
      input [`SISR_ADDR_W-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   reg  [1:0] spare_q;
   reg  [1:0] spare_d;
   reg  [3:0] compat_revision_q;
   reg  [3:0] compat_revision_d;
   reg        power_on_d;
   reg  [7:0] rdata_d;
   wire [5:0] live_status;
   wire [7:0] ident_value;
   wire [7:0] status_value;
   wire       ident_wr;

   // -------------------------------------------------------------------
   // identification and revision register
   // -------------------------------------------------------------------
   assign ident_wr = i_reg_wr & hit(i_reg_addr, `SISR_IDENT_OFS)
                     & ~i_subsystem_write_lock;

   always @* begin
      spare_d           = spare_q;
      compat_revision_d = compat_revision_q;
      if (ident_wr) begin
         spare_d = i_reg_wdata[`SISR_SPARE_HI:`SISR_SPARE_LO];
         compat_revision_d = i_reg_wdata[`SISR_REV_HI:`SISR_REV_LO];
      end
   end

   // only the global reset reaches these fields; socket-level resets
   // elsewhere must not disturb what legacy software wrote here
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         spare_q           <= `SISR_SPARE_RST;
         compat_revision_q <= REV_RESET;
      end else begin
         spare_q           <= spare_d;
         compat_revision_q <= compat_revision_d;
      end
   end

   assign o_legacy_mode = (compat_revision_q == `SISR_LEGACY_REV);

   assign ident_value = {`SISR_INTERFACE_KIND,
                         spare_q,
                         compat_revision_q};

   // -------------------------------------------------------------------
   // socket power indication
   // -------------------------------------------------------------------
   // legacy mode uses a single power enable bit, the newer layout a
   // two-bit supply voltage field where zero means off
   always @* begin
      if (o_legacy_mode) begin
         power_on_d = i_power_ctrl[`SISR_PWR_LEG_EN];
      end else begin
         power_on_d = (i_power_ctrl[`SISR_PWR_VCC_HI:`SISR_PWR_VCC_LO]
                       != `SISR_PWR_VCC_OFF);
      end
   end

   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_socket_power_on <= 1'b0;
      end else begin
         o_socket_power_on <= power_on_d;
      end
   end

   // -------------------------------------------------------------------
   // interface status register
   // -------------------------------------------------------------------
   sisr_status_capture u_capture (
      .i_core_clk               (i_core_clk),
      .i_rst_n                  (i_rst_n),
      .i_card_is_io             (i_card_is_io),
      .i_card_ready_pin         (i_card_ready_pin),
      .i_card_write_protect_pin (i_card_write_protect_pin),
      .i_card_detect_a_pin_n    (i_card_detect_a_pin_n),
      .i_card_detect_b_pin_n    (i_card_detect_b_pin_n),
      .i_battery_detect_a_pin   (i_battery_detect_a_pin),
      .i_battery_detect_b_pin   (i_battery_detect_b_pin),
      .i_card_speaker_pin       (i_card_speaker_pin),
      .i_card_status_change_pin (i_card_status_change_pin),
      .o_live_status            (live_status),
      .o_live_changed           (o_status_changed)
   );

   // no write path exists for this register
   assign status_value = {1'b0, o_socket_power_on, live_status};

   // live_status carries status bits 5:0 at their own positions
   assign o_card_fully_seated = live_status[`SISR_ST_CD_B]
                                & live_status[`SISR_ST_CD_A];

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   always @* begin
      if (hit(i_reg_addr, `SISR_IDENT_OFS)) begin
         rdata_d = ident_value;
      end else if (hit(i_reg_addr, `SISR_STATUS_OFS)) begin
         rdata_d = status_value;
      end else begin
         rdata_d = 8'h00;
      end
   end

   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_reg_rdata  <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rdata_d;
         end
      end
   end

endmodule

// *** tb/sisr_card_model.sv ***
// Purpose: inserted card driving the detect and low status lines
// Assumes: card type and line levels are chosen by the bench
// Notes: lines the card type leaves unused change every cycle
`timescale 1ns/100ps
module sisr_card_model (
   input  wire       i_core_clk,
   input  wire       i_is_io,
   input  wire [1:0] i_seat,
   input  wire [1:0] i_low,
   output wire [1:0] o_detect_n,
   output wire [1:0] o_batt,
   output wire [1:0] o_io_lines
);
   // a stuck unused line could hide a wrong card-type select
   logic tog_q = 1'b0;
   always @(posedge i_core_clk) begin
      tog_q <= ~tog_q;
   end
   assign o_detect_n = ~i_seat;
   assign o_batt     = i_is_io ? {tog_q, ~tog_q} : i_low;
   assign o_io_lines = i_is_io ? i_low : {~tog_q, tog_q};
endmodule

// *** tb/sisr_regs_chk.sv ***
// Purpose: port checks of the socket identification and status regs
// Assumes: a status read returns pins sampled one edge before it
// Notes: bound into every sisr_regs instance
`timescale 1ns/100ps
module sisr_regs_chk (
   input wire        i_core_clk,
   input wire        i_rst_n,
   input wire [11:0] i_reg_addr,
   input wire        i_reg_wr,
   input wire        i_reg_rd,
   input wire [7:0]  i_reg_wdata,
   input wire [7:0]  o_reg_rdata,
   input wire        o_reg_rvalid,
   input wire        i_subsystem_write_lock,
   input wire        i_card_ready_pin,
   input wire        i_card_write_protect_pin,
   input wire        i_card_detect_a_pin_n,
   input wire        i_card_detect_b_pin_n,
   input wire        o_legacy_mode
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_id_rd; i_reg_rd && i_reg_addr == 12'h800; endsequence
   sequence s_st_rd; i_reg_rd && i_reg_addr == 12'h801; endsequence
   sequence s_id_wr; i_reg_wr && i_reg_addr == 12'h800; endsequence
   a_read_answer:
      assert property (i_reg_rd |=> o_reg_rvalid) else $error("no rvalid");
   a_kind_fixed:
      assert property (s_id_rd |=> o_reg_rdata[7:6] == 2'b10)
      else $error("kind not 10");
   a_status_msb:
      assert property (s_st_rd |=> !o_reg_rdata[7]) else $error("bit7 set");
   a_ready_wp:
      assert property (s_st_rd |=> o_reg_rdata[5:4] ==
         {$past(i_card_ready_pin, 2), $past(i_card_write_protect_pin, 2)})
      else $error("ready or wp bit wrong");
   a_detect_inv:
      assert property (s_st_rd |=> o_reg_rdata[3:2] ==
         ~{$past(i_card_detect_b_pin_n, 2), $past(i_card_detect_a_pin_n, 2)})
      else $error("detect bits wrong");
   a_legacy_set:
      assert property (s_id_wr ##0 (!i_subsystem_write_lock &&
         i_reg_wdata[3:0] == 4'h2) |=> o_legacy_mode) else $error("no legacy");
   a_legacy_clear:
      assert property (s_id_wr ##0 (!i_subsystem_write_lock &&
         i_reg_wdata[3:0] != 4'h2) |=> !o_legacy_mode) else $error("legacy");
   a_lock_holds:
      assert property (s_id_wr ##0 i_subsystem_write_lock |=>
         $stable(o_legacy_mode)) else $error("locked write took effect");
endmodule
bind sisr_regs sisr_regs_chk chk_u (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .i_subsystem_write_lock(i_subsystem_write_lock),
   .i_card_ready_pin(i_card_ready_pin),
   .i_card_write_protect_pin(i_card_write_protect_pin),
   .i_card_detect_a_pin_n(i_card_detect_a_pin_n),
   .i_card_detect_b_pin_n(i_card_detect_b_pin_n),
   .o_legacy_mode(o_legacy_mode));

// *** tb/sisr_regs_bench.sv ***
// Purpose: directed tests of the socket identification and status regs
// Assumes: rvalid comes exactly one edge after the read edge
// Notes: detect and low card lines come from the card model; ready and write-protect come from the bench
`timescale 1ns/100ps
module sisr_regs_bench;
   localparam [3:0] REV = 4'h1; // arbitrary revision loaded at reset
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic        lock = 1'b0, io = 1'b0, rdy = 1'b0, wp = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0]  wdata = 8'h00, pwr = 8'h00, v, e;
   logic [1:0]  seat = 2'h0, low = 2'h0;
   wire  [7:0]  rdata;
   wire  [1:0]  det_n, batt, iol;
   wire         rvalid, legacy, pwr_on, seated, chg;
   int          err_count = 0, total_checks = 0;
   initial forever #4 clk = ~clk;
   sisr_card_model card_u (.i_core_clk(clk), .i_is_io(io), .i_seat(seat),
      .i_low(low), .o_detect_n(det_n), .o_batt(batt), .o_io_lines(iol));
   sisr_regs #(.REV_RESET(REV)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_subsystem_write_lock(lock), .i_power_ctrl(pwr), .i_card_is_io(io),
      .i_card_ready_pin(rdy), .i_card_write_protect_pin(wp),
      .i_card_detect_a_pin_n(det_n[0]), .i_card_detect_b_pin_n(det_n[1]),
      .i_battery_detect_a_pin(batt[0]), .i_battery_detect_b_pin(batt[1]),
      .i_card_speaker_pin(iol[1]), .i_card_status_change_pin(iol[0]),
      .o_legacy_mode(legacy), .o_socket_power_on(pwr_on),
      .o_card_fully_seated(seated), .o_status_changed(chg));
   task automatic check8(input string what, input logic [7:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk) begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
      end
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge clk) begin
         addr <= a;
         rd <= 1'b1;
      end
      @(posedge clk) rd <= 1'b0;
      @(posedge clk);
      if (rvalid === 1'b1)
         d = rdata;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] x,
                         input string what);
      reg_rd(a, v);
      check8(what, x, v);
   endtask
   task automatic pwr_chk(input logic [7:0] p, input logic x);
      @(posedge clk) pwr <= p;
      @(posedge clk);
      reg_rd(12'h801, v);
      check8("power bit", {1'b0, x, 6'h00}, v & 8'h40);
      check8("power out", {7'h00, x}, {7'h00, pwr_on});
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      print_verdict;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(12'h800, {4'h8, REV}, "ident reset");
      reg_rd(12'h801, v);
      check8("status top", 8'h00, v & 8'hc0);
      reg_wr(12'h800, 8'hff);
      rd_chk(12'h800, 8'hbf, "ident ones");
      reg_wr(12'h800, 8'h32);
      rd_chk(12'h800, 8'hb2, "ident legacy");
      check8("legacy on", 8'h01, {7'h00, legacy});
      $display("ident test done");
      @(posedge clk) lock <= 1'b1;
      reg_wr(12'h800, 8'h05);
      rd_chk(12'h800, 8'hb2, "ident locked");
      @(posedge clk) lock <= 1'b0;
      reg_wr(12'h801, 8'hff);
      reg_rd(12'h801, v);
      check8("status bit7", 8'h00, v & 8'h80);
      rd_chk(12'h823, 8'h00, "unmapped");
      $display("lock test done");
      pwr_chk(8'h10, 1'b1);
      pwr_chk(8'h08, 1'b0);
      reg_wr(12'h800, 8'h01);
      @(posedge clk);
      check8("legacy off", 8'h00, {7'h00, legacy});
      pwr_chk(8'h08, 1'b1);
      pwr_chk(8'h00, 1'b0);
      $display("power test done");
      for (int i = 0; i < 128; i++) begin
         @(posedge clk) {io, seat, rdy, wp, low} <= i[6:0];
         reg_rd(12'h801, v);
         e = {2'b00, rdy, wp, seat, low};
         check8("status", e, v);
         check8("seated", {7'h00, &seat}, {7'h00, seated});
      end
      // pin flips at m, is sampled at m+1, pulse stands from m+1 to m+2
      @(posedge clk) rdy <= ~rdy;
      @(posedge clk);
      @(posedge clk) check8("changed", 8'h01, {7'h00, chg});
      @(posedge clk) check8("quiet", 8'h00, {7'h00, chg});
      $display("status test done");
      reg_wr(12'h800, 8'h3f);
      @(posedge clk) rst_n <= 1'b0;
      @(posedge clk) rst_n <= 1'b1;
      rd_chk(12'h800, {4'h8, REV}, "ident again");
      $display("reset test done");
      print_verdict;
   end
endmodule
